// ---- pkg/fspc_pkg.sv ----
// constants and types shared by the flash segment and protocol configuration logic
`default_nettype none

package fspc_pkg;

  // ----------------------------------------------------------------
  // command codes of the configuration register commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WR_SEGMENT = 8'hA1;
  localparam logic [7:0] CMD_RD_SEGMENT = 8'hA2;
  localparam logic [7:0] CMD_WR_SETUP = 8'hA3;
  localparam logic [7:0] CMD_RD_SETUP = 8'hA4;

  // ----------------------------------------------------------------
  // segment_extension layout
  // ----------------------------------------------------------------
  localparam int SEG_SELECT_BIT = 0;
  localparam logic [7:0] SEG_WRITE_MASK = 8'h01;
  localparam logic [7:0] SEG_RESET = 8'h00;
  localparam int NV_SEG_DEFAULT_BIT = 1;

  // ----------------------------------------------------------------
  // enhanced_volatile_setup layout
  // ----------------------------------------------------------------
  localparam int QUAD_OFF_BIT = 7;
  localparam int DUAL_OFF_BIT = 6;
  localparam int SETUP_RSVD_BIT = 5;
  localparam int HOLD_EN_BIT = 4;
  localparam int VPP_OFF_BIT = 3;
  localparam int DRIVE_MSB = 2;
  localparam int DRIVE_LSB = 0;
  localparam logic [7:0] SETUP_WRITE_MASK = 8'hDF;
  localparam logic [7:0] SETUP_RESET = 8'hDF;

  // ----------------------------------------------------------------
  // drive strength codes and their impedance in ohms
  // ----------------------------------------------------------------
  localparam logic [2:0] DRIVE_90 = 3'h1;
  localparam logic [2:0] DRIVE_60 = 3'h2;
  localparam logic [2:0] DRIVE_45 = 3'h3;
  localparam logic [2:0] DRIVE_20 = 3'h5;
  localparam logic [2:0] DRIVE_15 = 3'h6;
  localparam logic [2:0] DRIVE_30 = 3'h7;

  // ----------------------------------------------------------------
  // array addressing
  // ----------------------------------------------------------------
  localparam int ARRAY_AW = 25;
  localparam int SEG_SPLIT_BIT = 24;

  typedef enum logic [1:0] {
    PROTO_EXTENDED = 2'b00,
    PROTO_DUAL = 2'b01,
    PROTO_QUAD = 2'b10
  } fspc_proto_t;

  typedef enum logic [1:0] {
    ACC_READ = 2'b00,
    ACC_PROGRAM = 2'b01,
    ACC_ERASE = 2'b10,
    ACC_BULK = 2'b11
  } fspc_access_t;

  typedef struct packed {
    logic [7:0] segExt;
    logic [7:0] evSetup;
    logic strapPending;
    logic [7:0] rdData;
    logic rdValid;
    logic flagAddrMode;
  } fspc_regs_t;

  typedef struct packed {
    logic [ARRAY_AW-1:0] arrayAddr;
    fspc_access_t kind;
    logic fourByte;
    logic wholeArray;
  } fspc_addr_t;

endpackage : fspc_pkg

`default_nettype wire

// ---- rtl/fspc_addr_path.sv ----
// array address former and continuous-access address counter
`timescale 1ns/100ps
`default_nettype none

module fspc_addr_path (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic accessStart,
  input wire fspc_pkg::fspc_access_t accessKind,
  input wire logic [31:0] accessAddr,
  input wire logic fourByteMode,
  input wire logic segSelect,
  input wire logic accessAdvance,
  output logic [fspc_pkg::ARRAY_AW-1:0] arrayAddr,
  output logic wholeArray
);

  fspc_pkg::fspc_addr_t st;
  fspc_pkg::fspc_addr_t next_st;

  // ----------------------------------------------------------------
  // address update
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (accessStart) begin
      next_st.kind = accessKind;
      next_st.fourByte = fourByteMode;
      next_st.wholeArray = (accessKind == fspc_pkg::ACC_BULK); // R4
      if (accessKind == fspc_pkg::ACC_BULK) begin
        next_st.arrayAddr = '0; // R4
      end else if (fourByteMode) begin
        next_st.arrayAddr = accessAddr[fspc_pkg::ARRAY_AW-1:0]; // R9
      end else begin
        next_st.arrayAddr = {segSelect, accessAddr[fspc_pkg::SEG_SPLIT_BIT-1:0]}; // R1 R2
      end
    end else if (accessAdvance && !st.wholeArray) begin
      if (st.kind == fspc_pkg::ACC_READ || st.fourByte) begin
        // natural wrap through zero lets one read stream the whole array
        next_st.arrayAddr = st.arrayAddr + 25'h0000001; // R5
      end else begin
        // 3-byte program and erase never step out of their segment
        next_st.arrayAddr[fspc_pkg::SEG_SPLIT_BIT-1:0] =
          st.arrayAddr[fspc_pkg::SEG_SPLIT_BIT-1:0] + 24'h000001; // R3
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{arrayAddr: '0, kind: fspc_pkg::ACC_READ, fourByte: 1'b0, wholeArray: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign arrayAddr = st.arrayAddr;
  assign wholeArray = st.wholeArray;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_three_byte_top: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    accessStart && !fourByteMode && accessKind != fspc_pkg::ACC_BULK
    |=> arrayAddr[fspc_pkg::SEG_SPLIT_BIT] == $past(segSelect)
        && arrayAddr[23:0] == $past(accessAddr[23:0]))
    else $error("3-byte access did not take the segment bit");

  a_four_byte_addr: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
    accessStart && fourByteMode && accessKind != fspc_pkg::ACC_BULK
    |=> arrayAddr == $past(accessAddr[24:0]))
    else $error("4-byte access did not use its own address");

  a_bulk_whole: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    accessStart && accessKind == fspc_pkg::ACC_BULK |=> wholeArray && arrayAddr == '0)
    else $error("bulk erase not applied to the whole array");

  a_read_wrap: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
    !accessStart && accessAdvance && !wholeArray && st.kind == fspc_pkg::ACC_READ && (&arrayAddr)
    |=> arrayAddr == '0)
    else $error("continuous read did not wrap to zero");

  a_prog_in_seg: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    !accessStart && accessAdvance && st.kind != fspc_pkg::ACC_READ && !st.fourByte
    |=> $stable(arrayAddr[fspc_pkg::SEG_SPLIT_BIT]))
    else $error("program or erase left its segment");

endmodule : fspc_addr_path

`default_nettype wire

// ---- rtl/fspc_config_regs.sv ----
// segment extension and enhanced volatile setup registers of the flash configuration logic
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// (R1) 3-byte accesses take top byte from segment register
// (R2) bit 0 picks lower or upper array half
// (R3) 3-byte program and erase stay in segment
// (R4) bulk erase clears both segments always
// (R5) continuous read wraps through zero across segments
// (R6) read crossing segments keeps segment bit unchanged
// (R7) segment bit loads from nonvolatile bit 1
// (R8) host rewrites segment bit; new value used after
// (R9) 4-byte mode ignores the segment register
// (R10) bit 7 low enables quad, default high
// (R11) bit 6 low enables dual, default high
// (R12) both low means quad wins over dual
// (R13) protocol changes only after the write completes
// (R14) setup commands accepted in every protocol
// (R15) bit 4 enables hold/reset, default enabled
// (R16) bit 3 low enables supply acceleration, default off
// (R17) bits 2:0 hold drive strength, default 111
// (R18) flag bit 0 reports 3- or 4-byte mode
// (R19) reserved bits read zero, writes ignored
module fspc_config_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] nvConfig,
  input wire logic cmdStart,
  input wire logic cmdDone,
  input wire logic [7:0] cmdOpcode,
  input wire logic [7:0] cmdWrData,
  input wire logic fourByteMode,
  input wire logic accessStart,
  input wire fspc_pkg::fspc_access_t accessKind,
  input wire logic [31:0] accessAddr,
  input wire logic accessAdvance,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic [fspc_pkg::ARRAY_AW-1:0] arrayAddr,
  output logic wholeArray,
  output logic segSelect,
  output fspc_pkg::fspc_proto_t activeProtocol,
  output logic holdResetEn,
  output logic vppAccelEn,
  output logic [2:0] driveCode,
  output logic [6:0] driveOhms,
  output logic driveReserved,
  output logic flagAddrMode
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic fspc_pkg::fspc_proto_t proto_of(input logic [7:0] setup);
    fspc_pkg::fspc_proto_t p;
    p = fspc_pkg::PROTO_EXTENDED;
    if (!setup[fspc_pkg::QUAD_OFF_BIT]) begin
      p = fspc_pkg::PROTO_QUAD; // R10 R12
    end else if (!setup[fspc_pkg::DUAL_OFF_BIT]) begin
      p = fspc_pkg::PROTO_DUAL; // R11
    end
    return p;
  endfunction : proto_of

  function automatic logic [6:0] ohms_of(input logic [2:0] code);
    logic [6:0] o;
    o = 7'h00;
    case (code)
      fspc_pkg::DRIVE_90: o = 7'h5A;
      fspc_pkg::DRIVE_60: o = 7'h3C;
      fspc_pkg::DRIVE_45: o = 7'h2D;
      fspc_pkg::DRIVE_20: o = 7'h14;
      fspc_pkg::DRIVE_15: o = 7'h0F;
      fspc_pkg::DRIVE_30: o = 7'h1E;
      default: o = 7'h00;
    endcase
    return o;
  endfunction : ohms_of

  fspc_pkg::fspc_regs_t st;
  fspc_pkg::fspc_regs_t next_st;
  logic wrSegment;
  logic wrSetup;
  logic rdSegment;
  logic rdSetup;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // no protocol term here: the setup commands must stay reachable in every protocol
  always_comb begin
    wrSegment = 1'b0;
    wrSetup = 1'b0;
    rdSegment = 1'b0;
    rdSetup = 1'b0;
    if (cmdDone && cmdOpcode == fspc_pkg::CMD_WR_SEGMENT) begin
      wrSegment = 1'b1; // R8
    end else if (cmdDone && cmdOpcode == fspc_pkg::CMD_WR_SETUP) begin
      wrSetup = 1'b1; // R13 R14
    end
    if (cmdStart && cmdOpcode == fspc_pkg::CMD_RD_SEGMENT) begin
      rdSegment = 1'b1;
    end else if (cmdStart && cmdOpcode == fspc_pkg::CMD_RD_SETUP) begin
      rdSetup = 1'b1; // R14
    end
  end

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdValid = 1'b0;
    next_st.flagAddrMode = fourByteMode; // R18
    if (st.strapPending) begin
      // strap is caught on the first edge after reset release, never under reset
      next_st.strapPending = 1'b0;
      next_st.segExt = {7'h00, nvConfig[fspc_pkg::NV_SEG_DEFAULT_BIT]}; // R7
    end else if (wrSegment) begin
      next_st.segExt = cmdWrData & fspc_pkg::SEG_WRITE_MASK; // R8 R19
    end
    if (wrSetup) begin
      // the whole value lands at command completion, so the protocol never switches mid-command
      next_st.evSetup = cmdWrData & fspc_pkg::SETUP_WRITE_MASK; // R13 R19
    end
    if (rdSegment) begin
      next_st.rdData = st.segExt & fspc_pkg::SEG_WRITE_MASK; // R19
      next_st.rdValid = 1'b1;
    end else if (rdSetup) begin
      next_st.rdData = st.evSetup & fspc_pkg::SETUP_WRITE_MASK; // R14 R19
      next_st.rdValid = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{segExt: fspc_pkg::SEG_RESET, evSetup: fspc_pkg::SETUP_RESET, strapPending: 1'b1,
              rdData: 8'h00, rdValid: 1'b0, flagAddrMode: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdData = st.rdData;
  assign rdValid = st.rdValid;
  assign flagAddrMode = st.flagAddrMode; // R18
  assign segSelect = st.segExt[fspc_pkg::SEG_SELECT_BIT]; // R2
  assign activeProtocol = proto_of(st.evSetup); // R10 R11 R12
  assign holdResetEn = st.evSetup[fspc_pkg::HOLD_EN_BIT]; // R15
  assign vppAccelEn = !st.evSetup[fspc_pkg::VPP_OFF_BIT]; // R16
  assign driveCode = st.evSetup[fspc_pkg::DRIVE_MSB:fspc_pkg::DRIVE_LSB]; // R17
  assign driveOhms = ohms_of(driveCode); // R17
  assign driveReserved = (ohms_of(driveCode) == 7'h00); // R17

  // ----------------------------------------------------------------
  // address path
  // ----------------------------------------------------------------
  // the path only reads the segment bit, so a read crossing halves cannot alter it
  fspc_addr_path u_addr_path (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .accessStart(accessStart),
    .accessKind(accessKind),
    .accessAddr(accessAddr),
    .fourByteMode(fourByteMode),
    .segSelect(segSelect),
    .accessAdvance(accessAdvance),
    .arrayAddr(arrayAddr),
    .wholeArray(wholeArray)
  ); // R6

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_strap_load: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    st.strapPending |=> segSelect == $past(nvConfig[1]) && !st.strapPending)
    else $error("segment bit not loaded from nonvolatile bit 1");

  a_segment_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
    !st.strapPending && cmdDone && cmdOpcode == fspc_pkg::CMD_WR_SEGMENT
    |=> st.segExt == {7'h00, $past(cmdWrData[0])})
    else $error("segment write not applied");

  a_segment_stable: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    !st.strapPending && !(cmdDone && cmdOpcode == fspc_pkg::CMD_WR_SEGMENT)
    |=> $stable(st.segExt))
    else $error("segment bit changed without a write");

  a_protocol_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
    !(cmdDone && cmdOpcode == fspc_pkg::CMD_WR_SETUP) |=> $stable(activeProtocol))
    else $error("protocol changed without a completed setup write");

  a_quad_priority: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
    cmdDone && cmdOpcode == fspc_pkg::CMD_WR_SETUP && !cmdWrData[7]
    |=> activeProtocol == fspc_pkg::PROTO_QUAD
        ##1 (activeProtocol == fspc_pkg::PROTO_QUAD
             || $past(cmdDone && cmdOpcode == fspc_pkg::CMD_WR_SETUP)))
    else $error("quad not selected after clearing bit 7");

  a_dual_select: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
    cmdDone && cmdOpcode == fspc_pkg::CMD_WR_SETUP && cmdWrData[7] && !cmdWrData[6]
    |=> activeProtocol == fspc_pkg::PROTO_DUAL)
    else $error("dual not selected");

  a_setup_readback: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
    cmdStart && cmdOpcode == fspc_pkg::CMD_RD_SETUP
    |=> rdValid && rdData == ($past(st.evSetup) & 8'hDF) ##1 !rdValid || $past(cmdStart))
    else $error("setup read-back wrong");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
    st.segExt[7:1] == 7'h00 && !st.evSetup[5])
    else $error("reserved bit set");

  a_setup_fields: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
    cmdDone && cmdOpcode == fspc_pkg::CMD_WR_SETUP
    |=> holdResetEn == $past(cmdWrData[4]) && vppAccelEn == !$past(cmdWrData[3])
        && driveCode == $past(cmdWrData[2:0]))
    else $error("setup fields not applied"); // R16 R17

  a_flag_mode: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
    ##1 flagAddrMode == $past(fourByteMode))
    else $error("addressing flag does not follow mode");

endmodule : fspc_config_regs

`default_nettype wire

// ---- verification/fspc_host_model.sv ----
// host controller model issuing configuration commands and array accesses
`timescale 1ns/100ps
`default_nettype none

module fspc_host_model (
  input wire logic core_clk,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  output logic cmdStart,
  output logic cmdDone,
  output logic [7:0] cmdOpcode,
  output logic [7:0] cmdWrData,
  output logic accessStart,
  output fspc_pkg::fspc_access_t accessKind,
  output logic [31:0] accessAddr,
  output logic accessAdvance
);
  initial begin
    cmdStart = 1'b0;
    cmdDone = 1'b0;
    cmdOpcode = 8'h00;
    cmdWrData = 8'h00;
    accessStart = 1'b0;
    accessKind = fspc_pkg::ACC_READ;
    accessAddr = 32'h0;
    accessAdvance = 1'b0;
  end

  // ----------------------------------------------------------------
  // register commands, split so a caller can look between the ends
  // ----------------------------------------------------------------
  task automatic cmd_open(input logic [7:0] op, input logic [7:0] data);
    @(negedge core_clk);
    cmdStart = 1'b1;
    cmdOpcode = op;
    cmdWrData = data;
  endtask : cmd_open

  // idle data is inverted so a stale byte never looks valid
  task automatic cmd_close();
    @(negedge core_clk);
    cmdStart = 1'b0;
    cmdDone = 1'b1;
    @(negedge core_clk);
    cmdDone = 1'b0;
    cmdOpcode = 8'h00;
    cmdWrData = ~cmdWrData;
  endtask : cmd_close

  task automatic reg_write(input logic [7:0] op, input logic [7:0] data);
    cmd_open(op, data);
    cmd_close();
  endtask : reg_write

  task automatic reg_read(input logic [7:0] op, output logic [7:0] data, output logic valid);
    @(negedge core_clk);
    cmdStart = 1'b1;
    cmdOpcode = op;
    @(negedge core_clk);
    cmdStart = 1'b0;
    cmdOpcode = 8'h00;
    data = rdData;
    valid = rdValid;
  endtask : reg_read

  // ----------------------------------------------------------------
  // array accesses
  // ----------------------------------------------------------------
  task automatic access(input fspc_pkg::fspc_access_t kind, input logic [31:0] addr);
    @(negedge core_clk);
    accessStart = 1'b1;
    accessKind = kind;
    accessAddr = addr;
    @(negedge core_clk);
    accessStart = 1'b0;
    accessAddr = ~addr;
  endtask : access

  task automatic advance();
    @(negedge core_clk);
    accessAdvance = 1'b1;
    @(negedge core_clk);
    accessAdvance = 1'b0;
  endtask : advance
endmodule : fspc_host_model

`default_nettype wire

// ---- verification/tb_flash_segment_and_protocol_config.sv ----
// self-checking testbench of the flash segment and protocol configuration logic
`timescale 1ns/100ps
`default_nettype none

module tb_flash_segment_and_protocol_config;
  logic core_clk, rst_n, fourByteMode, cmdStart, cmdDone, accessStart, accessAdvance;
  logic [7:0] nvConfig, cmdOpcode, cmdWrData, rdData;
  logic [31:0] accessAddr;
  fspc_pkg::fspc_access_t accessKind;
  logic rdValid, wholeArray, segSelect, holdResetEn, vppAccelEn, driveReserved, flagAddrMode;
  logic [fspc_pkg::ARRAY_AW-1:0] arrayAddr;
  fspc_pkg::fspc_proto_t activeProtocol;
  logic [2:0] driveCode;
  logic [6:0] driveOhms;
  int n_mismatch = 0;
  int checks = 0;

  fspc_config_regs dut (.core_clk(core_clk), .rst_n(rst_n), .nvConfig(nvConfig), .cmdStart(cmdStart),
    .cmdDone(cmdDone), .cmdOpcode(cmdOpcode), .cmdWrData(cmdWrData), .fourByteMode(fourByteMode),
    .accessStart(accessStart), .accessKind(accessKind), .accessAddr(accessAddr),
    .accessAdvance(accessAdvance), .rdData(rdData), .rdValid(rdValid), .arrayAddr(arrayAddr),
    .wholeArray(wholeArray), .segSelect(segSelect), .activeProtocol(activeProtocol),
    .holdResetEn(holdResetEn), .vppAccelEn(vppAccelEn), .driveCode(driveCode), .driveOhms(driveOhms),
    .driveReserved(driveReserved), .flagAddrMode(flagAddrMode));

  fspc_host_model host (.core_clk(core_clk), .rdData(rdData), .rdValid(rdValid), .cmdStart(cmdStart),
    .cmdDone(cmdDone), .cmdOpcode(cmdOpcode), .cmdWrData(cmdWrData), .accessStart(accessStart),
    .accessKind(accessKind), .accessAddr(accessAddr), .accessAdvance(accessAdvance));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // compare and closing
  // ----------------------------------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset(input logic [7:0] nv);
    rst_n = 1'b0;
    nvConfig = nv;
    fourByteMode = 1'b0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check_val("segSelect", nv[1], segSelect);
    check_val("activeProtocol", fspc_pkg::PROTO_EXTENDED, activeProtocol);
    check_val("holdResetEn", 1, holdResetEn);
    check_val("vppAccelEn", 0, vppAccelEn);
    check_val("driveCode", 7, driveCode);
    check_val("flagAddrMode", 0, flagAddrMode);
  endtask : t_reset

  // each write must leave the old protocol in place until it completes
  task automatic t_protocol();
    logic [7:0] wr [4] = '{8'hBF, 8'h7F, 8'h1F, 8'hFF};
    fspc_pkg::fspc_proto_t pr [4] = '{fspc_pkg::PROTO_DUAL, fspc_pkg::PROTO_QUAD, fspc_pkg::PROTO_QUAD,
      fspc_pkg::PROTO_EXTENDED};
    fspc_pkg::fspc_proto_t prev;
    logic [7:0] d;
    logic v;
    prev = fspc_pkg::PROTO_EXTENDED;
    for (int i = 0; i < 4; i++) begin
      host.cmd_open(fspc_pkg::CMD_WR_SETUP, wr[i]);
      @(negedge core_clk);
      check_val("protocol before done", prev, activeProtocol);
      host.cmd_close();
      check_val("activeProtocol", pr[i], activeProtocol);
      host.reg_read(fspc_pkg::CMD_RD_SETUP, d, v);
      check_val("rdValid", 1, v);
      check_val("setup readback", wr[i] & 8'hDF, d);
      prev = pr[i];
    end
  endtask : t_protocol

  task automatic t_fields();
    logic [6:0] ohms [8] = '{0, 90, 60, 45, 0, 20, 15, 30};
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      host.reg_write(fspc_pkg::CMD_WR_SETUP, {3'b110, c[0], c[1], c});
      check_val("holdResetEn", c[0], holdResetEn);
      check_val("vppAccelEn", !c[1], vppAccelEn);
      check_val("driveCode", c, driveCode);
      check_val("driveOhms", ohms[i], driveOhms);
      check_val("driveReserved", (c == 3'h0 || c == 3'h4), driveReserved);
    end
  endtask : t_fields

  task automatic t_segment();
    logic [7:0] d;
    logic v;
    host.reg_write(fspc_pkg::CMD_WR_SEGMENT, 8'hFF);
    check_val("segSelect", 1, segSelect);
    host.reg_read(fspc_pkg::CMD_RD_SEGMENT, d, v);
    check_val("rdValid", 1, v);
    check_val("segment readback", 8'h01, d);
    host.reg_write(fspc_pkg::CMD_WR_SEGMENT, 8'h00);
    check_val("segSelect", 0, segSelect);
  endtask : t_segment

  // start address, address after one step, and the bulk flag, per access
  task automatic t_address();
    logic sg [7] = '{0, 1, 1, 0, 1, 0, 1};
    logic fb [7] = '{0, 0, 0, 0, 0, 1, 1};
    fspc_pkg::fspc_access_t kd [7] = '{fspc_pkg::ACC_READ, fspc_pkg::ACC_READ, fspc_pkg::ACC_PROGRAM,
      fspc_pkg::ACC_ERASE, fspc_pkg::ACC_BULK, fspc_pkg::ACC_READ, fspc_pkg::ACC_ERASE};
    logic [31:0] ad [7] = '{32'hFFFFFF, 32'hFFFFFF, 32'hFFFFFF, 32'hAB123456, 32'h123456, 32'h1FFFFFF,
      32'h10};
    logic [24:0] e0 [7] = '{25'h0FFFFFF, 25'h1FFFFFF, 25'h1FFFFFF, 25'h0123456, 25'h0, 25'h1FFFFFF, 25'h10};
    logic [24:0] e1 [7] = '{25'h1000000, 25'h0, 25'h1000000, 25'h0123457, 25'h0, 25'h0, 25'h11};
    for (int i = 0; i < 7; i++) begin
      host.reg_write(fspc_pkg::CMD_WR_SEGMENT, {7'h00, sg[i]});
      fourByteMode = fb[i];
      host.access(kd[i], ad[i]);
      check_val("arrayAddr start", e0[i], arrayAddr);
      check_val("wholeArray", (kd[i] == fspc_pkg::ACC_BULK), wholeArray);
      check_val("flagAddrMode", fb[i], flagAddrMode);
      host.advance();
      check_val("arrayAddr step", e1[i], arrayAddr);
      check_val("segSelect kept", sg[i], segSelect);
    end
    fourByteMode = 1'b0;
  endtask : t_address

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    t_reset(8'h02);
    t_protocol();
    t_fields();
    t_segment();
    t_address();
    t_reset(8'h00);
    report_and_stop();
  end

  // the full sequence needs well under 1000 cycles
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_flash_segment_and_protocol_config

`default_nettype wire
